// ===== inc/dacsl_pkg.sv
package dacsl_pkg;
  // Frame geometry
  localparam int SHIFT_W    = 16;
  localparam int DATA_W     = 10;
  localparam int SUBLSB_W   = 2;
  localparam int LATCH_W    = 12;
  localparam int DUMMY_W    = 4;
  localparam int FULL_SCALE = 1024;
  // Field positions inside the shift register
  localparam int DATA_LSB   = 2;
  localparam int DATA_MSB   = 11;
  // Reset values
  localparam logic [9:0]  DAC_RST   = 10'h000;
  localparam logic [15:0] SHIFT_RST = 16'h0000;
  // Link clock: host divider, half period in system clocks
  localparam int SYS_CLK_NS     = 25;
  localparam int LINK_HALF_NS   = 100;
  localparam int LINK_HALF_CYC  = (LINK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  // Select high time between frames
  localparam int SEL_HIGH_NS    = 20;
  localparam int SEL_HIGH_CYC   = (SEL_HIGH_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
endpackage

// ===== inc/dacsl_link_if.sv
`timescale 1ns/100ps
interface dacsl_link_if;
  logic selectN;   // Active-low select
  logic shiftClk;  // Shift clock from host
  logic serIn;     // Serial data into device
  logic cascOut;   // Cascade output from device

  modport host (output selectN, output shiftClk, output serIn, input cascOut);
  modport dev  (input selectN, input shiftClk, input serIn, output cascOut);
endinterface // dacsl_link_if

// ===== src/dacsl_device.sv
`timescale 1ns/100ps
module dacsl_device (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  dacsl_link_if.dev              link,
  output logic [9:0]             dacCode,
  output logic                   dacUpdate
);
  ////////////////////////////////////////////////////////////////////////
  // Local geometry from the shared package
  localparam int SHIFT_W = dacsl_pkg::SHIFT_W;  // Input shift register
  localparam int DATA_W  = dacsl_pkg::DATA_W;   // DAC register
  localparam int N_PIN   = 3;                   // Select, clock, data
  localparam int PIN_SEL = 0;                   // Pin slot of select
  localparam int PIN_CLK = 1;                   // Pin slot of clock
  localparam int PIN_DIN = 2;                   // Pin slot of data

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Pins come from the host's domain
  // Each passes two flops before logic reads it

  // Raw pins, gathered for one loop
  wire [N_PIN-1:0] pinRaw;
  // Rest levels, so reset makes no false edge
  wire [N_PIN-1:0] pinIdle;
  // Second flop of each pin
  wire [N_PIN-1:0] pinSync;
  // Second flop, one clock older; the data pin takes the second flop itself
  wire [N_PIN-1:0] pinPrev;

  // Pin gathering
  assign pinRaw[PIN_SEL]  = link.selectN;
  assign pinRaw[PIN_CLK]  = link.shiftClk;
  assign pinRaw[PIN_DIN]  = link.serIn;

  // Select rests high, clock and data low
  assign pinIdle[PIN_SEL] = 1'h1;
  assign pinIdle[PIN_CLK] = 1'h0;
  assign pinIdle[PIN_DIN] = 1'h0;

  // Two flops per pin
  for (genvar p = 0; p < N_PIN; p++) begin : g_pin
    logic meta_ff;
    logic sync_ff;

    // Synchroniser chain of this pin
    always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
        meta_ff <= pinIdle[p];
        sync_ff <= pinIdle[p];
      end else begin
        meta_ff <= pinRaw[p];
        sync_ff <= meta_ff;
      end
    end

    // Settled level
    assign pinSync[p] = sync_ff;

    // Edge copy, only where an edge is wanted
    if (p == PIN_DIN) begin : g_level
      assign pinPrev[p] = sync_ff;  // Data is used as a level
    end else begin : g_edge
      logic prev_ff;

      // Older copy of the settled level
      always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
          prev_ff <= pinIdle[p];
        end else begin
          prev_ff <= sync_ff;
        end
      end

      assign pinPrev[p] = prev_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge decode

  // Select level and data bit after sync
  wire selLow  = ~pinSync[PIN_SEL];
  wire serBit  = pinSync[PIN_DIN];
  // Edges against the older copy
  wire clkRise = pinSync[PIN_CLK] & ~pinPrev[PIN_CLK];
  wire clkFall = ~pinSync[PIN_CLK] & pinPrev[PIN_CLK];
  wire selRise = pinSync[PIN_SEL] & ~pinPrev[PIN_SEL];

  // Shift only on a rise while selected
  wire shiftEn = selLow & clkRise;
  // Cascade only on a fall while selected
  wire cascEn  = selLow & clkFall;

  ////////////////////////////////////////////////////////////////////////
  // Input shift register, one stage per bit

  // Half periods of several clocks cover the sync delay
  // Data is steady well before each settled rise

  // Stage outputs
  wire [SHIFT_W-1:0] shiftQ;
  // Stage inputs
  wire [SHIFT_W-1:0] shiftD;

  // MSB first: each stage takes the one below
  assign shiftD = {shiftQ[SHIFT_W-2:0], serBit};

  // One flop per stage
  for (genvar b = 0; b < SHIFT_W; b++) begin : g_stage
    logic bit_ff;

    always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
        bit_ff <= dacsl_pkg::SHIFT_RST[b];
      end else if (shiftEn) begin
        bit_ff <= shiftD[b];
      end
    end

    // Stage output
    assign shiftQ[b] = bit_ff;
  end

  ////////////////////////////////////////////////////////////////////////
  // DAC register and load strobe

  logic [DATA_W-1:0] dac_ff;
  logic              upd_ff;

  wire [DATA_W-1:0] nxt_dac = shiftQ[dacsl_pkg::DATA_MSB:dacsl_pkg::DATA_LSB];

  // Cleared by reset, loaded on select rise
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dac_ff <= dacsl_pkg::DAC_RST;
    end else if (selRise) begin
      dac_ff <= nxt_dac;
    end
  end

  // Load strobe, same edge as the load
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      upd_ff <= 1'h0;
    end else begin
      upd_ff <= selRise;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cascade output

  // Always driven: a chained part never sees a floating input
  // Only the top stage feeds it, so the delay is the full register

  logic casc_ff;

  // Top stage out on a fall, held otherwise
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      casc_ff <= 1'h0;
    end else if (cascEn) begin
      casc_ff <= shiftQ[SHIFT_W-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Code is straight binary of 2*ref*N/1024
  assign dacCode      = dac_ff;
  assign dacUpdate    = upd_ff;
  assign link.cascOut = casc_ff;
endmodule // dacsl_device

// ===== src/dacsl_host.sv
`timescale 1ns/100ps
module dacsl_host #(
  parameter int FRAME_W = 16
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        reqValid,
  input  wire logic [9:0]  reqCode,
  output logic             reqReady,
  output logic [15:0]      echoWord,
  output logic             echoValid,
  dacsl_link_if.host       link
);
  typedef enum {IDLE, LOW, HIGH, GAP} dacsl_state_t;
  dacsl_state_t state_ff;
  logic [15:0] tx_ff;
  logic [15:0] rx_ff;
  logic [4:0]  bits_ff;
  logic [3:0]  div_ff;
  logic        sel_ff;
  logic        sclk_ff;
  logic        rdy_ff;
  logic        echoV_ff;
  logic [15:0] echo_ff;
  logic [1:0]  doutSync_ff;

  wire [15:0] frame = {4'h0, reqCode, 2'h0};
  wire [15:0] txInit = frame << (16 - FRAME_W);
  wire        divDone = (div_ff == 4'(dacsl_pkg::LINK_HALF_CYC - 1));

  ////////////////////////////////////////////////////////////////////////
  // Cascade input synchroniser
  always_ff @(posedge clk_sys) begin
    if (!rst_b) doutSync_ff <= 2'h0;
    else doutSync_ff <= {doutSync_ff[0], link.cascOut};
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer; select moves only with clock low
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_ff <= IDLE;
      tx_ff <= 16'h0000;
      rx_ff <= 16'h0000;
      bits_ff <= 5'h00;
      div_ff <= 4'h0;
      sel_ff <= 1'h1;
      sclk_ff <= 1'h0;
      rdy_ff <= 1'h1;
      echoV_ff <= 1'h0;
      echo_ff <= 16'h0000;
    end else begin
      echoV_ff <= 1'h0;
      div_ff <= divDone ? 4'h0 : div_ff + 4'h1;
      case (state_ff)
        IDLE: begin
          div_ff <= 4'h0;
          if (reqValid && rdy_ff) begin
            tx_ff <= txInit;
            bits_ff <= 5'(FRAME_W);
            sel_ff <= 1'h0;
            rdy_ff <= 1'h0;
            state_ff <= LOW;
          end
        end
        LOW: if (divDone) begin
          if (bits_ff == 5'h00) begin
            sel_ff <= 1'h1;
            echo_ff <= rx_ff;
            echoV_ff <= 1'h1;
            state_ff <= GAP;
          end else begin
            sclk_ff <= 1'h1;
            state_ff <= HIGH;
          end
        end
        HIGH: if (divDone) begin
          sclk_ff <= 1'h0;
          tx_ff <= {tx_ff[14:0], 1'h0};
          rx_ff <= {rx_ff[14:0], doutSync_ff[1]};
          bits_ff <= bits_ff - 5'h01;
          state_ff <= LOW;
        end
        GAP: if (divDone) begin
          rdy_ff <= 1'h1;
          state_ff <= IDLE;
        end
        default: state_ff <= IDLE;
      endcase
    end
  end

  assign link.selectN  = sel_ff;
  assign link.shiftClk = sclk_ff;
  assign link.serIn    = tx_ff[15];
  assign reqReady      = rdy_ff;
  assign echoWord      = echo_ff;
  assign echoValid     = echoV_ff;
endmodule // dacsl_host

// ===== verification/dacsl_link_sva.sv
`timescale 1ns/100ps
module dacsl_link_sva (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic selectN,
  input wire logic shiftClk,
  input wire logic serIn,
  input wire logic cascOut
);
  logic [15:0] hist_ff;
  logic [4:0]  riseCnt_ff;
  logic        clkLast_ff;
  wire         clkRise = shiftClk & ~clkLast_ff & ~selectN;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // Mirror of bits taken and rises per frame
  always_ff @(posedge clk_sys) begin
    clkLast_ff <= rst_b & shiftClk;
    hist_ff    <= !rst_b ? 16'h0000 : (clkRise ? {hist_ff[14:0], serIn} : hist_ff);
    riseCnt_ff <= (!rst_b || selectN) ? 5'h00 : riseCnt_ff + {4'h0, clkRise};
  end
  ////////////////////////////////////////
  chk_casc_fall: assert property ($changed(cascOut) |-> !selectN && !shiftClk)
    else $error("cascade moved outside a low clock phase");
  chk_casc_hold: assert property (selectN && $past(selectN) |-> $stable(cascOut))
    else $error("cascade moved while deselected");
  chk_casc_delay: assert property ($fell(shiftClk) && !selectN |-> ##[1:4] cascOut == hist_ff[15])
    else $error("cascade bit not sixteen rises old");
  chk_frame_len: assert property ($rose(selectN) |-> riseCnt_ff == 5'h10)
    else $error("frame length not sixteen");
  chk_pad_zero: assert property (clkRise && (riseCnt_ff < 5'h04 || riseCnt_ff > 5'h0d) |-> !serIn)
    else $error("dummy or sub-LSB bit not zero");
  chk_sel_clklow: assert property ($changed(selectN) |-> !shiftClk)
    else $error("select moved with clock high");
  chk_idle_clk: assert property (selectN |-> !shiftClk)
    else $error("clock high while deselected");
  chk_reset_idle: assert property ($rose(rst_b) |-> selectN && !shiftClk && !cascOut)
    else $error("link not idle after reset");
  chk_sel_gap: assert property ($rose(selectN) |-> selectN [*4])
    else $error("select high too short");
  cover property ($rose(selectN));
  cover property ($rose(cascOut));
  cover property (clkRise && serIn);
endmodule // dacsl_link_sva

// ===== verification/test_dac_serial_load_interface.sv
`timescale 1ns/100ps
module test_dac_serial_load_interface;
  logic        clk_sys  = 1'b0;
  logic        rst_b    = 1'b0;
  logic        reqValid = 1'b0;
  logic [9:0]  reqCode  = 10'h000;
  logic        reqReady, echoValid, dacUpdate;
  logic [15:0] echoWord, prevWord;
  logic [9:0]  dacCode;
  logic [31:0] rnd;
  int          seed = 58;
  int          n_mismatch = 0;
  int          checked = 0;
  dacsl_link_if link ();
  always #12.5 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  dacsl_host #(.FRAME_W(16)) i_dacsl_host (.clk_sys(clk_sys), .rst_b(rst_b),
    .reqValid(reqValid), .reqCode(reqCode), .reqReady(reqReady), .echoWord(echoWord),
    .echoValid(echoValid), .link(link.host));
  dacsl_device i_dacsl_device (.clk_sys(clk_sys), .rst_b(rst_b), .link(link.dev),
    .dacCode(dacCode), .dacUpdate(dacUpdate));
  dacsl_link_sva i_dacsl_link_sva (.clk_sys(clk_sys), .rst_b(rst_b),
    .selectN(link.selectN), .shiftClk(link.shiftClk), .serIn(link.serIn),
    .cascOut(link.cascOut));
  ////////////////////////////////////////
  // Compare and verdict
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Word on the wire for one code
  function automatic logic [15:0] frame_word(input logic [9:0] c);
    return {4'h0, c, 2'b00};
  endfunction
  // One frame, then echo and load checks
  task automatic send(input logic [9:0] c);
    int k;
    k = 0;
    while (reqReady !== 1'b1 && k < 50) begin
      @(posedge clk_sys);
      #1 k++;
    end
    if (k == 50) n_mismatch++;
    reqValid = 1'b1;
    reqCode  = c;
    @(posedge clk_sys);
    #1 reqValid = 1'b0;
    k = 0;
    while (echoValid !== 1'b1 && k < 400) begin
      @(posedge clk_sys);
      #1 k++;
    end
    if (k == 400) n_mismatch++;
    check("echo", echoWord, prevWord);
    prevWord = frame_word(c);
    k = 0;
    while (dacUpdate !== 1'b1 && k < 20) begin
      @(posedge clk_sys);
      #1 k++;
    end
    if (k == 20) n_mismatch++;
    check("code", {6'h00, dacCode}, {6'h00, c});
    $display("frame %h done", c);
  endtask
  ////////////////////////////////////////
  // Corners first, then random codes
  initial begin
    prevWord = 16'h0000;
    repeat (2) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    check("reset", {6'h00, dacCode}, 16'h0000);
    send(10'h3ff);
    send(10'h3ff);
    send(10'h200);
    send(10'h001);
    send(10'h000);
    repeat (10) begin
      rnd = $random(seed);
      send(rnd[9:0]);
    end
    print_verdict;
  end
  // Hang guard
  initial begin
    #200000 n_mismatch++;
    print_verdict;
  end
endmodule // test_dac_serial_load_interface
